// ==== src/arp_pkg.sv ====
package arp_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_PRIMARY_CONVERSION_RESULT   = 32'hFFFF051C;
    localparam logic [31:0] ADDR_AUXILIARY_CONVERSION_RESULT = 32'hFFFF0520;
    localparam logic [31:0] ADDR_PRIMARY_OFFSET_COEFFICIENT  = 32'hFFFF0524;
    localparam logic [31:0] ADDR_AUXILIARY_OFFSET_COEFFICIENT = 32'hFFFF0528;
    localparam logic [31:0] ADDR_PRIMARY_GAIN_COEFFICIENT    = 32'hFFFF052C;
    localparam logic [31:0] ADDR_AUXILIARY_GAIN_COEFFICIENT  = 32'hFFFF0530;
    localparam logic [31:0] ADDR_RESULT_COUNT_LIMIT          = 32'hFFFF0534;
    localparam logic [31:0] ADDR_RESULT_COUNT_VALUE          = 32'hFFFF0538;
    localparam logic [31:0] ADDR_MAGNITUDE_THRESHOLD         = 32'hFFFF053C;
    localparam logic [31:0] ADDR_THRESHOLD_HIT_LIMIT         = 32'hFFFF0540;
    localparam logic [31:0] ADDR_THRESHOLD_HIT_COUNT         = 32'hFFFF0544;
    localparam logic [31:0] ADDR_RESULT_ACCUMULATOR          = 32'hFFFF0548;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          RESULT_W             = 24;
    localparam int          COEF_W               = 16;
    localparam int          COUNT_W              = 16;
    localparam int          HIT_W                = 8;
    localparam int          ACC_W                = 32;
    localparam logic [15:0] RESULT_COUNT_LIMIT_RST = 16'h0001;
    localparam logic [7:0]  THRESHOLD_HIT_LIMIT_RST = 8'h01;
    localparam logic [15:0] MAGNITUDE_THRESHOLD_RST = 16'h0000;

    // Status bit positions of the ready flags
    localparam int READY_PRIMARY_BIT   = 0;
    localparam int READY_AUXILIARY_BIT = 1;

    // Idle time software must observe before writing coefficients
    localparam int IDLE_SETTLE_NS = 23000;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int IDLE_SETTLE_CYCLES = (IDLE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Mode encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] CMP_OFF        = 2'h0;
    localparam logic [1:0] CMP_EACH       = 2'h1;
    localparam logic [1:0] CMP_COUNT_CLR  = 2'h2;
    localparam logic [1:0] CMP_COUNT_DEC  = 2'h3;

    localparam logic [1:0] ACC_OFF        = 2'h0;
    localparam logic [1:0] ACC_CLAMP      = 2'h1;
    localparam logic [1:0] ACC_NOCLAMP    = 2'h2;
    localparam logic [1:0] ACC_WITH_CMP   = 2'h3;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                valid;
        logic [23:0]         data;
    } arp_result_type;

    typedef struct packed {
        logic                result_counter_enable;
        logic [1:0]          comparator_mode_field;
        logic [1:0]          acc_mode;
        logic                twos_comp;
    } arp_cfg_type;

    typedef struct packed {
        logic                valid;
        logic                auxiliary;
        logic                gain;
        logic [15:0]         value;
    } arp_cal_type;

    typedef struct packed {
        logic                rd;
        logic                wr;
        logic [31:0]         addr;
        logic [31:0]         wdata;
    } arp_mmr_req_type;

    // Result as a signed 25-bit value; unipolar codes are never negative
    function automatic logic signed [24:0] arp_signed_value(input logic [23:0] data,
                                                            input logic        twos);
        arp_signed_value = twos ? {data[23], data} : {1'b0, data};
    endfunction : arp_signed_value

endpackage : arp_pkg

// ==== src/arp_threshold.sv ====
module arp_threshold (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rst_b,
    input  wire arp_pkg::arp_result_type i_result,
    input  wire logic                    i_twos_comp,
    input  wire logic [1:0]              i_mode,
    input  wire logic [15:0]             i_threshold,
    input  wire logic [7:0]              i_hit_limit,
    output logic      [7:0]              o_hit_count,
    output logic                         o_event
);
    import arp_pkg::*;

    typedef struct packed {
        logic [7:0] hit_count;
        logic       event_hit;
    } arp_thr_state_type;

    arp_thr_state_type state;
    arp_thr_state_type next_state;
    logic signed [24:0] value;
    logic [24:0]        magnitude;
    logic               above;
    logic [7:0]         bumped;

    always_comb begin
        next_state = state;
        next_state.event_hit = 1'b0;
        value = arp_signed_value(i_result.data, i_twos_comp);
        magnitude = value[24] ? 25'(-value) : 25'(value);
        // Sixteen-bit compare on the top of the code; bipolar drops the sign bit
        if (i_twos_comp) begin
            above = (magnitude[23:8] >= {1'b0, i_threshold[14:0]});
        end else begin
            above = (magnitude[23:8] >= i_threshold);
        end
        bumped = (state.hit_count == 8'hFF) ? state.hit_count : state.hit_count + 8'h01;
        if (i_result.valid) begin
            case (i_mode)
                CMP_OFF: begin
                    next_state.hit_count = state.hit_count;
                end
                CMP_EACH: begin
                    next_state.event_hit = above;
                end
                CMP_COUNT_CLR: begin
                    if (above) begin
                        next_state.hit_count = bumped;
                        next_state.event_hit = (bumped == i_hit_limit);
                    end else begin
                        next_state.hit_count = 8'h00;
                    end
                end
                CMP_COUNT_DEC: begin
                    if (above) begin
                        next_state.hit_count = bumped;
                        next_state.event_hit = (bumped == i_hit_limit);
                    end else if (state.hit_count != 8'h00) begin
                        next_state.hit_count = state.hit_count - 8'h01;
                    end
                end
                default: begin
                    next_state.hit_count = state.hit_count;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_hit_count = state.hit_count;
    assign o_event     = state.event_hit;

endmodule : arp_threshold

// ==== src/arp_accumulator.sv ====
module arp_accumulator (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_rst_b,
    input  wire arp_pkg::arp_result_type i_result,
    input  wire logic                    i_twos_comp,
    input  wire logic [1:0]              i_mode,
    input  wire logic                    i_clear,
    output logic      [31:0]             o_acc
);
    import arp_pkg::*;

    typedef struct packed {
        logic [31:0] acc;
    } arp_acc_state_type;

    arp_acc_state_type  state;
    arp_acc_state_type  next_state;
    logic signed [32:0] sum;

    always_comb begin
        next_state = state;
        sum = $signed({1'b0, state.acc}) + 33'(arp_signed_value(i_result.data, i_twos_comp));
        if (i_clear || i_mode == ACC_OFF) begin
            next_state.acc = 32'h00000000;
        end else if (i_result.valid) begin
            case (i_mode)
                ACC_NOCLAMP: begin
                    next_state.acc = sum[31:0];
                end
                ACC_CLAMP, ACC_WITH_CMP: begin
                    // Clamp sends both underflow and a carry out of bit 31 to zero, since either one sets sum[32]
                    next_state.acc = sum[32] ? 32'h00000000 : sum[31:0];
                end
                default: begin
                    next_state.acc = state.acc;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_acc = state.acc;

endmodule : arp_accumulator

// ==== src/arp_result_post.sv ====
module arp_result_post #(
    parameter logic [15:0] PRIMARY_OFFSET_FACTORY   = 16'h8000,
    parameter logic [15:0] AUXILIARY_OFFSET_FACTORY = 16'h8000,
    parameter logic [15:0] PRIMARY_GAIN_FACTORY     = 16'h5555,
    parameter logic [15:0] AUXILIARY_GAIN_FACTORY   = 16'h5555
) (
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_rst_b,
    input  wire arp_pkg::arp_mmr_req_type i_mmr,
    output logic      [31:0]              o_mmr_rdata,
    input  wire arp_pkg::arp_cfg_type     i_cfg,
    input  wire logic                     i_primary_ctrl_wr,
    input  wire logic                     i_mode_wr,
    input  wire logic                     i_primary_idle,
    input  wire logic                     i_auxiliary_idle,
    input  wire arp_pkg::arp_result_type  i_primary_result,
    input  wire arp_pkg::arp_result_type  i_auxiliary_result,
    input  wire arp_pkg::arp_cal_type     i_cal,
    output logic      [1:0]               o_ready_flags,
    output logic                          o_threshold_flag,
    output logic                          o_primary_irq,
    output logic      [15:0]              o_primary_offset_coefficient,
    output logic      [15:0]              o_auxiliary_offset_coefficient,
    output logic      [15:0]              o_primary_gain_coefficient,
    output logic      [15:0]              o_auxiliary_gain_coefficient
);
    import arp_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [23:0] primary_conversion_result;
        logic [23:0] auxiliary_conversion_result;
        logic [1:0]  ready;
        logic [15:0] primary_offset_coefficient;
        logic [15:0] auxiliary_offset_coefficient;
        logic [15:0] primary_gain_coefficient;
        logic [15:0] auxiliary_gain_coefficient;
        logic [15:0] result_count_limit;
        logic [15:0] result_count_value;
        logic [15:0] magnitude_threshold;
        logic [7:0]  threshold_hit_limit;
        logic        threshold_flag;
        logic        irq;
        logic [31:0] rdata;
    } arp_top_state_type;

    arp_top_state_type state;
    arp_top_state_type next_state;

    logic [7:0]  threshold_hit_count;
    logic [31:0] result_accumulator;
    logic        threshold_event;
    logic        reconfig;
    logic        wr_primary_offset;
    logic        wr_auxiliary_offset;
    logic        wr_primary_gain;
    logic        wr_auxiliary_gain;
    logic        read_primary;
    logic [15:0] count_step;

    function automatic logic hit(input arp_mmr_req_type req, input logic [31:0] addr);
        hit = (req.addr == addr);
    endfunction : hit

    // ------------------------------------------------------------------
    // Comparator and accumulator on the primary stream
    // ------------------------------------------------------------------
    arp_threshold u_threshold (
        .i_sys_clk   (i_sys_clk),
        .i_rst_b     (i_rst_b),
        .i_result    (i_primary_result),
        .i_twos_comp (i_cfg.twos_comp),
        .i_mode      (i_cfg.comparator_mode_field),
        .i_threshold (state.magnitude_threshold),
        .i_hit_limit (state.threshold_hit_limit),
        .o_hit_count (threshold_hit_count),
        .o_event     (threshold_event)
    );

    arp_accumulator u_accumulator (
        .i_sys_clk   (i_sys_clk),
        .i_rst_b     (i_rst_b),
        .i_result    (i_primary_result),
        .i_twos_comp (i_cfg.twos_comp),
        .i_mode      (i_cfg.acc_mode),
        .i_clear     (reconfig),
        .o_acc       (result_accumulator)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.irq = 1'b0;
        reconfig = i_primary_ctrl_wr | i_mode_wr;
        read_primary = i_mmr.rd && hit(i_mmr, ADDR_PRIMARY_CONVERSION_RESULT);
        // Writes to read-only offsets fall through the decode untouched
        wr_primary_offset   = i_mmr.wr && hit(i_mmr, ADDR_PRIMARY_OFFSET_COEFFICIENT)
                              && i_primary_idle;
        wr_auxiliary_offset = i_mmr.wr && hit(i_mmr, ADDR_AUXILIARY_OFFSET_COEFFICIENT)
                              && i_auxiliary_idle;
        wr_primary_gain     = i_mmr.wr && hit(i_mmr, ADDR_PRIMARY_GAIN_COEFFICIENT)
                              && i_primary_idle;
        wr_auxiliary_gain   = i_mmr.wr && hit(i_mmr, ADDR_AUXILIARY_GAIN_COEFFICIENT)
                              && i_auxiliary_idle;
        count_step = state.result_count_value + 16'h0001;

        // Ready flags: a primary result read clears both, a new result in the same cycle wins
        if (read_primary) begin
            next_state.ready = 2'b00;
            next_state.threshold_flag = 1'b0;
        end
        if (i_primary_result.valid) begin
            if (!state.ready[READY_PRIMARY_BIT]) begin
                next_state.primary_conversion_result = i_primary_result.data;
            end
            next_state.ready[READY_PRIMARY_BIT] = 1'b1;
        end
        if (i_auxiliary_result.valid) begin
            if (!state.ready[READY_AUXILIARY_BIT]) begin
                next_state.auxiliary_conversion_result = i_auxiliary_result.data;
            end
            next_state.ready[READY_AUXILIARY_BIT] = 1'b1;
        end

        // Result counter decimates the primary interrupt
        if (reconfig) begin
            next_state.result_count_value = 16'h0000;
        end else if (i_primary_result.valid && i_cfg.result_counter_enable) begin
            if (count_step == state.result_count_limit) begin
                next_state.result_count_value = 16'h0000;
                next_state.irq = 1'b1;
            end else begin
                next_state.result_count_value = count_step;
            end
        end
        if (i_primary_result.valid && !i_cfg.result_counter_enable) begin
            next_state.irq = 1'b1;
        end

        if (threshold_event) begin
            next_state.threshold_flag = 1'b1;
            next_state.irq = 1'b1;
        end

        // Software writes to writable registers
        if (wr_primary_offset) begin
            next_state.primary_offset_coefficient = i_mmr.wdata[15:0];
        end
        if (wr_auxiliary_offset) begin
            next_state.auxiliary_offset_coefficient = i_mmr.wdata[15:0];
        end
        if (wr_primary_gain) begin
            next_state.primary_gain_coefficient = i_mmr.wdata[15:0];
        end
        if (wr_auxiliary_gain) begin
            next_state.auxiliary_gain_coefficient = i_mmr.wdata[15:0];
        end
        if (i_mmr.wr && hit(i_mmr, ADDR_RESULT_COUNT_LIMIT)) begin
            next_state.result_count_limit = i_mmr.wdata[15:0];
        end
        if (i_mmr.wr && hit(i_mmr, ADDR_MAGNITUDE_THRESHOLD)) begin
            next_state.magnitude_threshold = i_mmr.wdata[15:0];
        end
        if (i_mmr.wr && hit(i_mmr, ADDR_THRESHOLD_HIT_LIMIT)) begin
            next_state.threshold_hit_limit = i_mmr.wdata[7:0];
        end

        // Calibration results overwrite any software value in the same cycle
        if (i_cal.valid) begin
            case ({i_cal.auxiliary, i_cal.gain})
                2'b00: next_state.primary_offset_coefficient = i_cal.value;
                2'b10: next_state.auxiliary_offset_coefficient = i_cal.value;
                2'b01: next_state.primary_gain_coefficient = i_cal.value;
                2'b11: next_state.auxiliary_gain_coefficient = i_cal.value;
                default: next_state.primary_gain_coefficient = state.primary_gain_coefficient;
            endcase
        end

        // Read data, registered; unmapped offsets read zero
        if (i_mmr.rd) begin
            case (i_mmr.addr)
                ADDR_PRIMARY_CONVERSION_RESULT:
                    next_state.rdata = {8'h00, state.primary_conversion_result};
                ADDR_AUXILIARY_CONVERSION_RESULT:
                    next_state.rdata = {8'h00, state.auxiliary_conversion_result};
                ADDR_PRIMARY_OFFSET_COEFFICIENT:
                    next_state.rdata = {16'h0000, state.primary_offset_coefficient};
                ADDR_AUXILIARY_OFFSET_COEFFICIENT:
                    next_state.rdata = {16'h0000, state.auxiliary_offset_coefficient};
                ADDR_PRIMARY_GAIN_COEFFICIENT:
                    next_state.rdata = {16'h0000, state.primary_gain_coefficient};
                ADDR_AUXILIARY_GAIN_COEFFICIENT:
                    next_state.rdata = {16'h0000, state.auxiliary_gain_coefficient};
                ADDR_RESULT_COUNT_LIMIT:
                    next_state.rdata = {16'h0000, state.result_count_limit};
                ADDR_RESULT_COUNT_VALUE:
                    next_state.rdata = {16'h0000, state.result_count_value};
                ADDR_MAGNITUDE_THRESHOLD:
                    next_state.rdata = {16'h0000, state.magnitude_threshold};
                ADDR_THRESHOLD_HIT_LIMIT:
                    next_state.rdata = {24'h000000, state.threshold_hit_limit};
                ADDR_THRESHOLD_HIT_COUNT:
                    next_state.rdata = {24'h000000, threshold_hit_count};
                ADDR_RESULT_ACCUMULATOR:
                    next_state.rdata = result_accumulator;
                default:
                    next_state.rdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= '0;
            state.primary_offset_coefficient   <= PRIMARY_OFFSET_FACTORY;
            state.auxiliary_offset_coefficient <= AUXILIARY_OFFSET_FACTORY;
            state.primary_gain_coefficient     <= PRIMARY_GAIN_FACTORY;
            state.auxiliary_gain_coefficient   <= AUXILIARY_GAIN_FACTORY;
            state.result_count_limit           <= RESULT_COUNT_LIMIT_RST;
            state.magnitude_threshold          <= MAGNITUDE_THRESHOLD_RST;
            state.threshold_hit_limit          <= THRESHOLD_HIT_LIMIT_RST;
        end else begin
            state <= next_state;
        end
    end

    assign o_mmr_rdata                    = state.rdata;
    assign o_ready_flags                  = state.ready;
    assign o_threshold_flag               = state.threshold_flag;
    assign o_primary_irq                  = state.irq;
    assign o_primary_offset_coefficient   = state.primary_offset_coefficient;
    assign o_auxiliary_offset_coefficient = state.auxiliary_offset_coefficient;
    assign o_primary_gain_coefficient     = state.primary_gain_coefficient;
    assign o_auxiliary_gain_coefficient   = state.auxiliary_gain_coefficient;

endmodule : arp_result_post

// ==== bench/arp_result_post_properties.sv ====
module arp_result_post_properties
    import arp_pkg::*;
(
    input wire logic                     i_sys_clk,
    input wire logic                     i_rst_b,
    input wire arp_pkg::arp_mmr_req_type i_mmr,
    input wire arp_pkg::arp_cfg_type     i_cfg,
    input wire logic                     i_primary_idle,
    input wire arp_pkg::arp_result_type  i_primary_result,
    input wire arp_pkg::arp_result_type  i_auxiliary_result,
    input wire arp_pkg::arp_cal_type     i_cal,
    input wire logic [1:0]               o_ready_flags,
    input wire logic                     o_threshold_flag,
    input wire logic                     o_primary_irq,
    input wire logic [15:0]              o_primary_offset_coefficient,
    input wire logic [15:0]              o_primary_gain_coefficient,
    input wire logic [15:0]              o_auxiliary_gain_coefficient
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Checks on the block's ports
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    AST_READY_SET: assert property (i_primary_result.valid |=> o_ready_flags[0])
        else $error("primary ready flag not set");
    AST_READ_CLR: assert property (i_mmr.rd && i_mmr.addr == ADDR_PRIMARY_CONVERSION_RESULT
        && !i_primary_result.valid && !i_auxiliary_result.valid |=> o_ready_flags == 2'h0)
        else $error("ready flags not cleared by result read");
    AST_AUX_SET: assert property (i_auxiliary_result.valid |=> o_ready_flags[1])
        else $error("auxiliary ready flag not set");
    AST_OFS_CAL: assert property (i_cal.valid && !i_cal.auxiliary && !i_cal.gain
        |=> o_primary_offset_coefficient == $past(i_cal.value)) else $error("offset not loaded");
    AST_GAIN_CAL: assert property (i_cal.valid && i_cal.auxiliary && i_cal.gain
        |=> o_auxiliary_gain_coefficient == $past(i_cal.value)) else $error("gain not loaded");
    AST_IDLE_GUARD: assert property (i_mmr.wr && !i_primary_idle && !i_cal.valid
        && i_mmr.addr == ADDR_PRIMARY_GAIN_COEFFICIENT |=> $stable(o_primary_gain_coefficient))
        else $error("coefficient written while busy");
    AST_IRQ_EVERY: assert property (i_primary_result.valid && !i_cfg.result_counter_enable
        |=> o_primary_irq) else $error("interrupt missing");
    AST_IRQ_CAUSE: assert property (o_primary_irq
        |-> $past(i_primary_result.valid) || $past(i_primary_result.valid, 2))
        else $error("interrupt without result");
    AST_THR_CAUSE: assert property ($rose(o_threshold_flag)
        |-> $past(i_primary_result.valid, 2)) else $error("threshold flag without result");
endmodule : arp_result_post_properties

bind arp_result_post arp_result_post_properties u_props (.*);

// ==== bench/arp_result_post_test.sv ====
module arp_result_post_test;
    timeunit 1ns;
    timeprecision 1ns;
    import arp_pkg::*;
    logic clk, rst_b, ctrl_wr, mode_wr, p_idle, rd_d;
    logic [31:0] rdata, d1, d2, exp_q[$];
    string name_q[$];
    arp_mmr_req_type mmr;
    arp_cfg_type cfg;
    arp_result_type pres, ares;
    arp_cal_type cal;
    int mismatches = 0, comparisons = 0, cycles = 0;
    arp_result_post u_dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_mmr(mmr), .o_mmr_rdata(rdata),
        .i_cfg(cfg), .i_primary_ctrl_wr(ctrl_wr), .i_mode_wr(mode_wr), .i_primary_idle(p_idle),
        .i_auxiliary_idle(p_idle), .i_primary_result(pres), .i_auxiliary_result(ares),
        .i_cal(cal), .o_ready_flags(), .o_threshold_flag(), .o_primary_irq(),
        .o_primary_offset_coefficient(), .o_auxiliary_offset_coefficient(),
        .o_primary_gain_coefficient(), .o_auxiliary_gain_coefficient());
    // ------------------------------------------------------------------
    // Drivers and scoreboard
    // ------------------------------------------------------------------
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task automatic t(input int n = 1);
        repeat (n) @(posedge clk);
    endtask : t
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
        comparisons++;
        if (seen !== expd) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, expd, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    // Reads note their expectation; writes only drive
    task automatic bus(input logic rd, input logic [31:0] a, input logic [31:0] v);
        if (rd) begin
            exp_q.push_back(v);
            name_q.push_back($sformatf("reg %h", a));
        end
        mmr <= {rd, !rd, a, v};
        t();
        mmr <= '0;
        t();
    endtask : bus
    task automatic res(input logic [23:0] d);
        pres <= {1'b1, d};
        t();
        pres.valid <= 1'b0;
        t();
    endtask : res
    always @(posedge clk) begin
        rd_d <= mmr.rd;
        if (++cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    always @(negedge clk) begin
        if (rd_d === 1'b1) begin
            check(name_q.pop_front(), rdata, exp_q.pop_front());
        end
    end
    initial begin
        {mmr, cfg, ctrl_wr, mode_wr, p_idle, pres, ares, cal, rst_b} = '0;
        void'($urandom(36416));
        t(20);
        rst_b <= 1'b1;
        bus(1, ADDR_RESULT_COUNT_LIMIT, 32'h1);
        bus(1, ADDR_THRESHOLD_HIT_LIMIT, 32'h1);
        bus(1, ADDR_PRIMARY_OFFSET_COEFFICIENT, 32'h8000);
        bus(1, 32'hFFFF0600, 32'h0);
        d1 = $urandom & 32'hFFFFFF;
        d2 = ~d1 & 32'hFFFFFF;
        res(d1);
        res(d2);
        ares <= {1'b1, d2[23:0]};
        t();
        ares <= {1'b1, d1[23:0]};
        t();
        ares.valid <= 1'b0;
        bus(1, ADDR_AUXILIARY_CONVERSION_RESULT, d2);
        bus(1, ADDR_PRIMARY_CONVERSION_RESULT, d1);
        res(d2);
        bus(1, ADDR_PRIMARY_CONVERSION_RESULT, d2);
        cal <= {1'b1, 1'b0, 1'b0, d1[15:0]};
        t();
        cal <= {1'b1, 1'b1, 1'b1, d2[15:0]};
        t();
        cal.valid <= 1'b0;
        bus(1, ADDR_PRIMARY_OFFSET_COEFFICIENT, d1 & 32'hFFFF);
        bus(1, ADDR_AUXILIARY_GAIN_COEFFICIENT, d2 & 32'hFFFF);
        bus(0, ADDR_PRIMARY_GAIN_COEFFICIENT, 32'h1234);
        bus(1, ADDR_PRIMARY_GAIN_COEFFICIENT, 32'h5555);
        p_idle <= 1'b1;
        t(IDLE_SETTLE_CYCLES);
        bus(0, ADDR_PRIMARY_GAIN_COEFFICIENT, 32'h1234);
        bus(1, ADDR_PRIMARY_GAIN_COEFFICIENT, 32'h1234);
        cfg.result_counter_enable <= 1'b1;
        bus(0, ADDR_RESULT_COUNT_LIMIT, 32'h3);
        mode_wr <= 1'b1;
        t();
        mode_wr <= 1'b0;
        res(24'h1);
        res(24'h1);
        bus(0, ADDR_RESULT_COUNT_VALUE, 32'h55);
        bus(1, ADDR_RESULT_COUNT_VALUE, 32'h2);
        res(24'h1);
        bus(1, ADDR_RESULT_COUNT_VALUE, 32'h0);
        res(24'h1);
        ctrl_wr <= 1'b1;
        t();
        ctrl_wr <= 1'b0;
        bus(1, ADDR_RESULT_COUNT_VALUE, 32'h0);
        // Count-down mode must stop at zero, not wrap to 0xFF
        cfg.comparator_mode_field <= CMP_COUNT_DEC;
        bus(0, ADDR_THRESHOLD_HIT_LIMIT, 32'hFF);
        bus(0, ADDR_MAGNITUDE_THRESHOLD, 32'h10);
        for (int i = 0; i < 5; i++) res(i < 2 ? 24'h1000 : 24'h0F00);
        bus(1, ADDR_THRESHOLD_HIT_COUNT, 32'h0);
        cfg.comparator_mode_field <= CMP_COUNT_CLR;
        for (int i = 0; i < 3; i++) res(i < 2 ? 24'h1000 : 24'h0F00);
        bus(1, ADDR_THRESHOLD_HIT_COUNT, 32'h0);
        cfg.twos_comp <= 1'b1;
        bus(0, ADDR_MAGNITUDE_THRESHOLD, 32'h8010);
        res(24'hFFF000);
        bus(1, ADDR_THRESHOLD_HIT_COUNT, 32'h1);
        bus(0, ADDR_THRESHOLD_HIT_LIMIT, 32'h2);
        res(24'hFFF000);
        bus(1, ADDR_THRESHOLD_HIT_COUNT, 32'h2);
        cfg.acc_mode <= ACC_CLAMP;
        res(24'd100);
        res(24'hFFFED4);
        res(24'd50);
        cfg.acc_mode <= ACC_NOCLAMP;
        res(24'hFFFFC4);
        bus(1, ADDR_RESULT_ACCUMULATOR, 32'hFFFFFFF6);
        cfg.acc_mode <= ACC_OFF;
        t();
        bus(1, ADDR_RESULT_ACCUMULATOR, 32'h0);
        cfg.acc_mode <= ACC_WITH_CMP;
        res(24'd7);
        bus(1, ADDR_RESULT_ACCUMULATOR, 32'h7);
        give_verdict();
    end
endmodule : arp_result_post_test
